// File: dv/shp_slot_model.sv
// behavioural slot sensors: button, fault, command done, latch, card, link
`timescale 1ns/10ps
module shp_slot_model
   import shp_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic card_presence_strap,
   input wire logic [5:0] req,
   output shp_slot_in_t slot_in
);
   initial slot_in = '0;
   // pulses last one cycle; levels toggle on request, card resets to the inverted strap
   always @(posedge aclk) begin
      slot_in.attn_press <= req[0];
      slot_in.power_fault <= req[1];
      slot_in.cmd_done <= req[2];
      if (!aresetn) begin
         slot_in.card_present <= ~card_presence_strap;
         slot_in.dl_active <= 1'b0;
         slot_in.mrl_open <= 1'b0;
      end else begin
         slot_in.card_present <= slot_in.card_present ^ req[3];
         slot_in.dl_active <= slot_in.dl_active ^ req[4];
         slot_in.mrl_open <= slot_in.mrl_open ^ req[5];
      end
   end
endmodule : shp_slot_model

// File: dv/shp_slot_props.sv
// assertion checker for the slot hot-plug register bank
`timescale 1ns/10ps
module shp_slot_props
   import shp_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic slot_implemented,
   input wire shp_msg_t attn_msg,
   input wire shp_msg_t pwr_msg,
   input wire logic power_off,
   input wire logic hp_irq
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ----
   // write steps
   // ----
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // a message only ever rides on an accepted write to the word
   sequence wr_ok;
      s_axi_bvalid && s_axi_bresp == 2'h0;
   endsequence
   wr_resp_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
      else $error("write response missing");
   rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   rst_val_a: assert property ($rose(aresetn) |->
      attn_msg.code == SHP_IND_OFF && pwr_msg.code == SHP_IND_OFF
      && !power_off && !hp_irq)
      else $error("wrong value after reset");
   attn_msg_a: assert property (attn_msg.valid |-> wr_ok)
      else $error("attention message without write");
   pwr_msg_a: assert property (pwr_msg.valid |-> wr_ok)
      else $error("power message without write");
   pwr_ctl_a: assert property ($changed(power_off) |-> wr_ok)
      else $error("power control moved without write");
   no_slot_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h0
      && !slot_implemented |-> s_axi_rdata[22])
      else $error("presence low without slot");
   irq_clr_a: assert property ($fell(hp_irq) |->
      $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
      else $error("interrupt dropped without write");
endmodule : shp_slot_props
bind shp_slot_regs shp_slot_props chk_u (.*);

// File: dv/tb.sv
// self-checking bench for the slot hot-plug register bank
`timescale 1ns/10ps
`include "shp_params.svh"
module tb
   import shp_pkg::*;
;
   logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
   logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
   logic s_axi_bready = 1, s_axi_rready = 1;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, d, w;
   logic [3:0] s_axi_wstrb = '0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, power_off, hp_irq, hp_wake, pres;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic card_presence_strap = 0, slot_implemented = 1;
   logic [5:0] req = '0;
   logic [15:0] c;
   shp_slot_in_t slot_in;
   shp_msg_t attn_msg, pwr_msg;
   logic [1:0] exp_b[$], exp_a[$], exp_p[$];
   logic [33:0] exp_r[$];
   int num_errors = 0, cmp_count = 0, seed = 32'hfef2168d, n, i;
   int eb[5] = '{16, 17, 20, 19, 24};
   int en[5] = '{0, 1, 4, 3, 12};
   always #5 aclk = ~aclk;
   shp_slot_regs dut_u (.*);
   shp_slot_model mdl_u (.*);
   // ----
   // checking and closing
   // ----
   task automatic chk(logic [33:0] got, logic [33:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic end_sim();
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : end_sim
   // a wait that ran out is a hang: count it and stop
   task automatic lim(int k);
      if (k >= 40) begin
         num_errors++;
         end_sim();
      end
   endtask : lim
   // watcher takes the oldest note for each answer that appears
   always @(posedge aclk) begin
      if (s_axi_bvalid) chk(s_axi_bresp, exp_b.pop_front());
      if (s_axi_rvalid) chk({s_axi_rresp, s_axi_rdata}, exp_r.pop_front());
      if (attn_msg.valid) chk(attn_msg.code, exp_a.pop_front());
      if (pwr_msg.valid) chk(pwr_msg.code, exp_p.pop_front());
   end
   // ----
   // bus cycles
   // ----
   task automatic wr(logic [11:0] a, logic [31:0] dt, logic [3:0] s,
      logic [1:0] r);
      logic pa, pw;
      exp_b.push_back(r);
      s_axi_awaddr <= a;
      s_axi_wdata <= dt;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      pa = 1;
      pw = 1;
      for (n = 0; n < 40 && (pa || pw); n++) begin
         @(posedge aclk);
         pa = pa && !s_axi_awready;
         pw = pw && !s_axi_wready;
         s_axi_awvalid <= pa;
         s_axi_wvalid <= pw;
      end
      lim(n);
      for (n = 0; n < 40 && !s_axi_bvalid; n++) @(posedge aclk);
      lim(n);
   endtask : wr
   // control lanes only; both indicator fields are covered, so two notes
   task automatic ctl(logic [31:0] dt);
      exp_a.push_back(dt[7:6]);
      exp_p.push_back(dt[9:8]);
      wr(`SHP_SLOT_OFF, dt, 4'h3, 2'h0);
   endtask : ctl
   task automatic rd(logic [11:0] a, logic [33:0] e);
      exp_r.push_back(e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      for (n = 0; n < 40 && !s_axi_arready; n++) @(posedge aclk);
      lim(n);
      s_axi_arvalid <= 1'b0;
      for (n = 0; n < 40 && !s_axi_rvalid; n++) @(posedge aclk);
      lim(n);
   endtask : rd
   task automatic pulse(logic [5:0] r);
      req <= r;
      @(posedge aclk);
      req <= '0;
      repeat (4) @(posedge aclk);
   endtask : pulse
   // ----
   // scenarios
   // ----
   initial begin
      // reset twice, once per strap level; second reset lands mid-run
      for (i = 1; i >= 0; i--) begin
         card_presence_strap <= i[0];
         aresetn <= 1'b0;
         repeat (2) @(posedge aclk);
         aresetn <= 1'b1;
         @(posedge aclk);
         rd(`SHP_SLOT_OFF, {11'h0, ~i[0], 6'h0, 16'h03c0});
         chk(power_off, 0);
      end
      $display("test reset done");
      // every indicator code, random enables, reserved bits stay zero
      for (i = 0; i < 4; i++) begin
         d = $random(seed);
         d[9:6] = {i[1:0], i[1:0]};
         d[10] = i[0];
         c = d[15:0] & 16'h17fb;
         ctl(d);
         rd(`SHP_SLOT_OFF, {18'h40, c});
         chk(power_off, i[0]);
      end
      wr(12'h0dc, 32'hffff_ffff, 4'hf, 2'h2);
      rd(12'h0dc, {2'h2, 32'h0});
      rd(`SHP_SLOT_OFF, {18'h40, c});
      $display("test control done");
      // each event: latch while masked, unmask, then write one to clear
      pres = 1;
      for (i = 0; i < 5; i++) begin
         c = 16'h03c0 | (16'h1 << en[i]);
         ctl(c);
         pulse(6'h1 << i);
         pres = pres && i != 3;
         w = {9'h0, pres, 22'h0} | (32'h1 << eb[i]) | c;
         chk(hp_irq, 0);
         chk(hp_wake, i != 2);
         rd(`SHP_SLOT_OFF, {2'h0, w});
         ctl(c | 16'h20);
         repeat (3) @(posedge aclk);
         chk(hp_irq, 1);
         wr(`SHP_SLOT_OFF, 32'h1 << eb[i], 4'hc, 2'h0);
         rd(`SHP_SLOT_OFF, {2'h0, w & ~(32'h1 << eb[i]) | 32'h20});
         repeat (3) @(posedge aclk);
         chk(hp_irq, 0);
      end
      $display("test events done");
      // latch sensor: change flag and state are read only
      pulse(6'h20);
      wr(`SHP_SLOT_OFF, 32'h0024_0000, 4'hc, 2'h0);
      rd(`SHP_SLOT_OFF, {2'h0, 32'h0024_13e0});
      slot_implemented <= 1'b0;
      repeat (2) @(posedge aclk);
      rd(`SHP_SLOT_OFF, {2'h0, 32'h0064_13e0});
      $display("test sensors done");
      // a button press while the clock enable is low must leave no trace
      ce <= 1'b0;
      pulse(6'h1);
      ce <= 1'b1;
      rd(`SHP_SLOT_OFF, {2'h0, 32'h0064_13e0});
      $display("test freeze done");
      // let the watcher take the last answer; every message must have come
      repeat (2) @(posedge aclk);
      chk(exp_a.size() + exp_p.size(), 0);
      end_sim();
   end
endmodule : tb

// File: hdl/shp_params.svh
// constants of the downstream slot hot-plug register bank
`ifndef SHP_PARAMS_SVH
`define SHP_PARAMS_SVH
// ----------------------------------------------------------------------
// address map
// ----------------------------------------------------------------------
`define SHP_SLOT_OFF 12'h0d8
`define SHP_ADDR_W 12
// ----------------------------------------------------------------------
// slot control fields (low half of the word)
// ----------------------------------------------------------------------
`define SHP_ABP_EN_BIT 0
`define SHP_PFD_EN_BIT 1
`define SHP_PDC_EN_BIT 3
`define SHP_CC_EN_BIT 4
`define SHP_HPI_EN_BIT 5
`define SHP_ATTN_LSB 6
`define SHP_PWRI_LSB 8
`define SHP_PWR_CTL_BIT 10
`define SHP_DLLSC_EN_BIT 12
`define SHP_IND_RESET 2'h3
// ----------------------------------------------------------------------
// slot status fields (high half of the word)
// ----------------------------------------------------------------------
`define SHP_ABP_BIT 16
`define SHP_PFD_BIT 17
`define SHP_MRLSC_BIT 18
`define SHP_PDC_BIT 19
`define SHP_CC_BIT 20
`define SHP_MRLS_BIT 21
`define SHP_PDS_BIT 22
`define SHP_DLLSC_BIT 24
`endif

// File: hdl/shp_pkg.sv
// types of the downstream slot hot-plug register bank
package shp_pkg;
   // indicator encodings
   typedef enum logic [1:0] {
      SHP_IND_RSVD  = 2'h0,
      SHP_IND_ON    = 2'h1,
      SHP_IND_BLINK = 2'h2,
      SHP_IND_OFF   = 2'h3
   } shp_ind_t;

   // slot side inputs
   typedef struct packed {
      logic attn_press;    // one-cycle pulse
      logic power_fault;   // one-cycle pulse
      logic cmd_done;      // one-cycle pulse
      logic mrl_open;      // level
      logic card_present;  // level
      logic dl_active;     // level, data link control in active state
   } shp_slot_in_t;

   // indicator message request towards the downstream link
   typedef struct packed {
      logic valid;
      shp_ind_t code;
   } shp_msg_t;

   typedef enum logic [1:0] {
      SHP_WR_IDLE,
      SHP_WR_RESP
   } shp_wr_st_t;
endpackage : shp_pkg

// File: hdl/shp_slot_regs.sv
// slot control / slot status registers of a downstream switch port
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/10ps
`include "shp_params.svh"

module shp_slot_regs
   import shp_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // axi4-lite slave
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // slot side
   input wire shp_slot_in_t slot_in,
   input wire logic card_presence_strap,
   input wire logic slot_implemented,
   output shp_msg_t attn_msg,
   output shp_msg_t pwr_msg,
   output logic power_off,
   output logic hp_irq,
   output logic hp_wake
);

   // ---------------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------------
   // byte enables widened to a bit mask
   function automatic logic [31:0] strb_mask(input logic [3:0] s);
      logic [31:0] m;
      m = '0;
      for (int i = 0; i < 4; i++) begin
         m[i*8 +: 8] = {8{s[i]}};
      end
      return m;
   endfunction : strb_mask

   // the one mapped word
   function automatic logic hits_slot(input logic [11:0] a);
      return a[11:2] == 10'(`SHP_SLOT_OFF >> 2);
   endfunction : hits_slot

   // ---------------------------------------------------------------------
   // state
   // ---------------------------------------------------------------------
   logic [11:0] awaddr_q;
   logic aw_got_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic w_got_q;
   shp_wr_st_t wr_st_q;
   logic wr_fire;
   logic wr_hit;
   logic [31:0] wr_mask;
   logic [15:0] ctl_q;
   logic [15:0] ctl_d;
   logic [4:0] flag_q;  // abp, pfd, pdc, cc, dllsc
   logic [4:0] flag_set;
   logic [4:0] flag_clr;
   logic [4:0] flag_en;
   logic mrl_chg_q;
   logic mrl_q;
   logic pres_q;
   logic link_act_q;
   logic [31:0] rd_word;
   logic pres_bit;

   // write is performed once address and data are both held
   assign wr_fire = ce && aw_got_q && w_got_q && wr_st_q == SHP_WR_IDLE;
   assign wr_hit = wr_fire && hits_slot(awaddr_q);
   assign wr_mask = strb_mask(wstrb_q);

   // ---------------------------------------------------------------------
   // axi write channels
   // ---------------------------------------------------------------------
   // address and data are taken independently, in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_q <= 1'b0;
         awaddr_q <= 12'h000;
         s_axi_awready <= 1'b0;
      end else if (ce) begin
         s_axi_awready <= 1'b0;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end else if (wr_fire) begin
            aw_got_q <= 1'b0;
         end else if (!aw_got_q && s_axi_awvalid) begin
            s_axi_awready <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_got_q <= 1'b0;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         s_axi_wready <= 1'b0;
      end else if (ce) begin
         s_axi_wready <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_got_q <= 1'b0;
         end else if (!w_got_q && s_axi_wvalid) begin
            s_axi_wready <= 1'b1;
         end
      end
   end

   // response follows both halves; unmapped words answer slverr
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_st_q <= SHP_WR_IDLE;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else if (ce) begin
         case (wr_st_q)
            SHP_WR_IDLE: begin
               if (wr_fire) begin
                  wr_st_q <= SHP_WR_RESP;
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp <= hits_slot(awaddr_q) ? 2'h0 : 2'h2;
               end
            end
            SHP_WR_RESP: begin
               if (s_axi_bready) begin
                  wr_st_q <= SHP_WR_IDLE;
                  s_axi_bvalid <= 1'b0;
               end
            end
            default: begin
               wr_st_q <= SHP_WR_IDLE;
               s_axi_bvalid <= 1'b0;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------------
   // slot control
   // ---------------------------------------------------------------------
   // only the documented bits are writable, reserved bits stay zero
   localparam logic [15:0] CTL_RW = 16'h17fb;
   localparam logic [15:0] CTL_RST =
      {6'h00, `SHP_IND_RESET, `SHP_IND_RESET, 6'h00};

   always_comb begin
      ctl_d = ctl_q;
      if (wr_hit) begin
         ctl_d = (ctl_q & ~(wr_mask[15:0] & CTL_RW)) |
                 (wdata_q[15:0] & wr_mask[15:0] & CTL_RW);
      end
   end

   // enables, indicators and power control
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctl_q <= CTL_RST;
      end else if (ce) begin
         ctl_q <= ctl_d;
      end
   end

   // power controller follows bit 10
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         power_off <= 1'b0;
      end else if (ce) begin
         power_off <= ctl_d[`SHP_PWR_CTL_BIT];
      end
   end

   // any write reaching an indicator byte lane resends that message,
   // even when the value is unchanged
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         attn_msg <= '{valid: 1'b0, code: SHP_IND_OFF};
         pwr_msg <= '{valid: 1'b0, code: SHP_IND_OFF};
      end else if (ce) begin
         attn_msg.valid <= wr_hit && wstrb_q[0];
         attn_msg.code <= shp_ind_t'(ctl_d[`SHP_ATTN_LSB +: 2]);
         pwr_msg.valid <= wr_hit && wstrb_q[1];
         pwr_msg.code <= shp_ind_t'(ctl_d[`SHP_PWRI_LSB +: 2]);
      end
   end

   // ---------------------------------------------------------------------
   // sensor tracking
   // ---------------------------------------------------------------------
   // presence is loaded from the strap while reset is held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pres_q <= !card_presence_strap;
         mrl_q <= 1'b0;
         link_act_q <= 1'b0;
      end else if (ce) begin
         pres_q <= slot_in.card_present;
         mrl_q <= slot_in.mrl_open;
         link_act_q <= slot_in.dl_active;
      end
   end

   // latch sensor change has no software clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mrl_chg_q <= 1'b0;
      end else if (ce && (slot_in.mrl_open != mrl_q)) begin
         mrl_chg_q <= 1'b1;
      end
   end

   // ---------------------------------------------------------------------
   // write-one-to-clear event flags
   // ---------------------------------------------------------------------
   assign flag_set = {
      slot_in.dl_active != link_act_q,
      slot_in.cmd_done,
      slot_in.card_present != pres_q,
      slot_in.power_fault,
      slot_in.attn_press
   };
   assign flag_clr = {5{wr_hit}} & {
      wdata_q[`SHP_DLLSC_BIT] & wr_mask[`SHP_DLLSC_BIT],
      wdata_q[`SHP_CC_BIT] & wr_mask[`SHP_CC_BIT],
      wdata_q[`SHP_PDC_BIT] & wr_mask[`SHP_PDC_BIT],
      wdata_q[`SHP_PFD_BIT] & wr_mask[`SHP_PFD_BIT],
      wdata_q[`SHP_ABP_BIT] & wr_mask[`SHP_ABP_BIT]
   };
   assign flag_en = {
      ctl_q[`SHP_DLLSC_EN_BIT],
      ctl_q[`SHP_CC_EN_BIT],
      ctl_q[`SHP_PDC_EN_BIT],
      ctl_q[`SHP_PFD_EN_BIT],
      ctl_q[`SHP_ABP_EN_BIT]
   };

   // a set in the clearing cycle wins, so no event is lost
   for (genvar g = 0; g < 5; g++) begin : g_flag
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            flag_q[g] <= 1'b0;
         end else if (ce) begin
            flag_q[g] <= (flag_q[g] & ~flag_clr[g]) | flag_set[g];
         end
      end
   end

   // ---------------------------------------------------------------------
   // notification outputs
   // ---------------------------------------------------------------------
   // wake ignores the master enable and the command flag, since
   // command completion only ever raises an interrupt
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hp_irq <= 1'b0;
         hp_wake <= 1'b0;
      end else if (ce) begin
         hp_irq <= ctl_q[`SHP_HPI_EN_BIT] && |(flag_q & flag_en);
         hp_wake <= |(flag_q & flag_en & 5'h17);
      end
   end

   // ---------------------------------------------------------------------
   // read channel
   // ---------------------------------------------------------------------
   assign pres_bit = slot_implemented ? pres_q : 1'b1;

   always_comb begin
      rd_word = '0;
      rd_word[15:0] = ctl_q;
      rd_word[`SHP_ABP_BIT] = flag_q[0];
      rd_word[`SHP_PFD_BIT] = flag_q[1];
      rd_word[`SHP_MRLSC_BIT] = mrl_chg_q;
      rd_word[`SHP_PDC_BIT] = flag_q[2];
      rd_word[`SHP_CC_BIT] = flag_q[3];
      rd_word[`SHP_MRLS_BIT] = mrl_q;
      rd_word[`SHP_PDS_BIT] = pres_bit;
      rd_word[`SHP_DLLSC_BIT] = flag_q[4];
   end

   // one read at a time; arready is offered only while idle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'h0;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= hits_slot(s_axi_araddr) ? rd_word : 32'h0;
            s_axi_rresp <= hits_slot(s_axi_araddr) ? 2'h0 : 2'h2;
         end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
               s_axi_rvalid <= 1'b0;
            end
         end else begin
            s_axi_arready <= s_axi_arvalid;
         end
      end
   end

endmodule : shp_slot_regs
